// ===== rtl/psc_mode_seq.v
// host sequencer that sends power-loss store enable/disable commands
// assumes: drives a byte-wide asynchronous memory, no other master on the port
`timescale 1ns/1ps
`include "psc_consts.vh"
// Function
// - first three reads go to 0x0e38, 0x31c7, 0x03e0 in order.
// - fourth and fifth reads go to 0x3c1f then 0x303f.
// - reads may be framed by chip select or by output enable.
// - new setting persists only after a later manual store.
// - six reads go out with no other access between them.
// - host re-issues the desired command after every reset.
// - write strobe stays high through all six reads.
module psc_mode_seq #(
  parameter AW = 15,
  parameter STORE_WAIT = `PSC_STORE_WAIT
) (
  input wire clk_sys,
  input wire rst_n,
  input wire cmd_valid,
  input wire cmd_enable,
  input wire cmd_persist,
  input wire cmd_use_pin,
  input wire cmd_oe_frame,
  output wire cmd_ready,
  output reg cmd_done,
  output reg want_enabled,
  output wire [AW-1:0] mem_addr,
  output wire mem_ce_n,
  output wire mem_oe_n,
  output wire mem_we_n,
  input wire hw_nv_flag_n_in,
  output reg hw_nv_flag_n_out,
  output reg hw_nv_flag_n_oe
);
  // sequencer states: a read is started in ST_ISSUE and finished in ST_WAIT;
  // the last three states only run when the new mode is to be made permanent,
  // either by the store pin or by a software store sequence
  localparam ST_IDLE = 3'h0;
  localparam ST_ISSUE = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_PIN = 3'h3;
  localparam ST_STORE_WAIT = 3'h4;
  localparam ST_BUSY = 3'h5;
  reg [2:0] state;
  // position within the six reads, and whether the store sequence is running
  reg [2:0] idx;
  reg phase_store;
  // command fields latched when the request is taken, so the caller may
  // change its inputs while the command runs
  reg persist;
  reg use_pin;
  reg oe_frame;
  reg enable;
  // one-cycle start pulse to the read engine
  reg rc_start;
  // store wait counter, reloaded from STORE_WAIT
  reg [15:0] wait_cnt;
  reg [13:0] next_addr;
  wire rc_busy;
  wire rc_done;
  wire last_read;
  // request accepted only when fully idle, so nothing interleaves
  assign cmd_ready = (state == ST_IDLE);
  // sixth read of a group: the command address or the store address
  assign last_read = (idx == `PSC_SEQ_LEN - 3'h1);
  // address of the current read of the six
  // combinational, but only taken by the engine on its start pulse
  always @* begin
    case (idx)
      3'h0: next_addr = `PSC_ADDR_SEQ1;
      3'h1: next_addr = `PSC_ADDR_SEQ2;
      3'h2: next_addr = `PSC_ADDR_SEQ3;
      3'h3: next_addr = `PSC_ADDR_SEQ4;
      3'h4: next_addr = `PSC_ADDR_SEQ5;
      default: begin
        if (phase_store) begin
          next_addr = `PSC_ADDR_STORE;
        end else if (enable) begin
          next_addr = `PSC_ADDR_ENA;
        end else begin
          next_addr = `PSC_ADDR_DIS;
        end
      end
    endcase
  end
  // read cycle engine; top address bit held low
  // the engine registers every memory pin, so nothing glitches between reads
  psc_read_cycle #(
    .AW(AW)
  ) u_cycle (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(rc_start),
    .addr({{(AW-14){1'b0}}, next_addr}),
    .use_oe_frame(oe_frame),
    .mem_addr(mem_addr),
    .mem_ce_n(mem_ce_n),
    .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n),
    .busy(rc_busy),
    .done(rc_done)
  );
  // command sequencer: six reads, then optionally a manual store by the pin or
  // by six more reads, then a one-cycle done pulse
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      // port quiet and pin released; the device is assumed to be as shipped,
      // which the caller should not rely on and re-issues its mode after reset
      state <= ST_IDLE;
      idx <= 3'h0;
      phase_store <= 1'b0;
      persist <= 1'b0;
      use_pin <= 1'b0;
      oe_frame <= 1'b0;
      enable <= 1'b1;
      rc_start <= 1'b0;
      wait_cnt <= 16'h0000;
      cmd_done <= 1'b0;
      want_enabled <= 1'b1;
      hw_nv_flag_n_out <= 1'b1;
      hw_nv_flag_n_oe <= 1'b1;
    end else begin
      rc_start <= 1'b0;
      cmd_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          // take a command only when idle; its fields are latched here
          if (cmd_valid) begin
            // re-issued by the user after each reset to set a known mode
            enable <= cmd_enable;
            persist <= cmd_persist;
            use_pin <= cmd_use_pin;
            oe_frame <= cmd_oe_frame;
            idx <= 3'h0;
            phase_store <= 1'b0;
            rc_start <= 1'b1;
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          // the engine takes the start pulse one edge later; waiting for busy
          // keeps the done pulse of the previous read from being seen twice
          if (rc_busy) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // a read finished: start the next one at once or close the group
          if (rc_done) begin
            if (!last_read) begin
              // next read follows at once, no other access
              idx <= idx + 3'h1;
              rc_start <= 1'b1;
              state <= ST_ISSUE;
            end else if (!phase_store) begin
              // the mode is now changed in the device; it is only kept over a
              // power loss once a manual store follows
              want_enabled <= enable;
              if (persist && use_pin) begin
                // pin store; skipped by the device without prior writes
                hw_nv_flag_n_out <= 1'b0;
                hw_nv_flag_n_oe <= 1'b0;
                wait_cnt <= STORE_WAIT[15:0];
                state <= ST_PIN;
              end else if (persist) begin
                phase_store <= 1'b1;
                idx <= 3'h0;
                rc_start <= 1'b1;
                state <= ST_ISSUE;
              end else begin
                cmd_done <= 1'b1;
                state <= ST_IDLE;
              end
            end else begin
              // software store started; the device is deaf until it finishes
              wait_cnt <= STORE_WAIT[15:0];
              state <= ST_STORE_WAIT;
            end
          end
        end
        ST_PIN: begin
          // hold the store request pin low for the wait time, then let it go;
          // the pull-up brings it back high
          if (wait_cnt == 16'h0001) begin
            hw_nv_flag_n_out <= 1'b1;
            hw_nv_flag_n_oe <= 1'b1;
            state <= ST_BUSY;
          end else begin
            wait_cnt <= wait_cnt - 16'h0001;
          end
        end
        ST_STORE_WAIT: begin
          // no access to the memory while the store runs
          if (wait_cnt == 16'h0001) begin
            state <= ST_BUSY;
          end else begin
            wait_cnt <= wait_cnt - 16'h0001;
          end
        end
        ST_BUSY: begin
          // device holds the pin low while storing; only a weak pull-up lifts
          // it afterwards, so this wait has no bound and a pin tied low stalls
          // the sequencer until reset
          if (hw_nv_flag_n_in) begin
            cmd_done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          // unused codes fall back to idle with the port quiet
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== rtl/psc_consts.vh
// constants for the power-loss store mode sequencer (host side)
// assumes: included by the sequencer rtl; definitions only
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH
// command address sequence (lower 14 bits matter)
`define PSC_ADDR_SEQ1 14'h0e38
`define PSC_ADDR_SEQ2 14'h31c7
`define PSC_ADDR_SEQ3 14'h03e0
`define PSC_ADDR_SEQ4 14'h3c1f
`define PSC_ADDR_SEQ5 14'h303f
`define PSC_ADDR_DIS 14'h03f8
`define PSC_ADDR_ENA 14'h07f0
`define PSC_ADDR_STORE 14'h0fc0
// number of reads in one command
`define PSC_SEQ_LEN 3'h6
// memory read cycle timing in clk_sys cycles (40 ns each)
`define PSC_SETUP_CYC 4'h1
`define PSC_STROBE_CYC 4'h2
`define PSC_HOLD_CYC 4'h1
// manual store wait after the sequence, in clk_sys cycles
`define PSC_STORE_WAIT 16'h0100
`endif

// ===== rtl/psc_read_cycle.v
// one asynchronous read cycle on the memory port
// assumes: memory pins registered out of this module, clk_sys 25 MHz
`timescale 1ns/1ps
module psc_read_cycle #(
  parameter AW = 15
) (
  input wire clk_sys,
  input wire rst_n,
  input wire start,
  input wire [AW-1:0] addr,
  input wire use_oe_frame,
  output reg [AW-1:0] mem_addr,
  output reg mem_ce_n,
  output reg mem_oe_n,
  output reg mem_we_n,
  output wire busy,
  output reg done
);
`include "psc_consts.vh"
  localparam ST_IDLE = 2'h0;
  localparam ST_SETUP = 2'h1;
  localparam ST_STROBE = 2'h2;
  localparam ST_HOLD = 2'h3;
  reg [1:0] state;
  reg [3:0] cnt;
  reg frame_oe;
  assign busy = (state != ST_IDLE);
  // one read: address setup, strobe low, hold with strobe high
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      frame_oe <= 1'b0;
      mem_addr <= {AW{1'b0}};
      mem_ce_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      mem_we_n <= 1'b1;
      case (state)
        ST_IDLE: begin
          if (start) begin
            mem_addr <= addr;
            frame_oe <= use_oe_frame;
            // the strobe not framing the cycle is held low beforehand
            mem_ce_n <= !use_oe_frame;
            mem_oe_n <= use_oe_frame;
            cnt <= `PSC_SETUP_CYC;
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt == 4'h1) begin
            // framing strobe falls
            mem_ce_n <= 1'b0;
            mem_oe_n <= 1'b0;
            cnt <= `PSC_STROBE_CYC;
            state <= ST_STROBE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_STROBE: begin
          if (cnt == 4'h1) begin
            if (frame_oe) begin
              mem_oe_n <= 1'b1;
            end else begin
              mem_ce_n <= 1'b1;
            end
            cnt <= `PSC_HOLD_CYC;
            state <= ST_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_HOLD: begin
          if (cnt == 4'h1) begin
            mem_ce_n <= 1'b1;
            mem_oe_n <= 1'b1;
            done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== test/psc_mode_seq_chk.sv
// port checker for the power-loss store mode sequencer
// assumes: bound onto psc_mode_seq, one clock domain
`timescale 1ns/1ps
module psc_mode_seq_chk #(
  parameter AW = 15,
  parameter STORE_WAIT = 256
) (
  input wire clk_sys,
  input wire rst_n,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire cmd_done,
  input wire want_enabled,
  input wire [AW-1:0] mem_addr,
  input wire mem_ce_n,
  input wire mem_oe_n,
  input wire mem_we_n,
  input wire hw_nv_flag_n_out,
  input wire hw_nv_flag_n_oe
);
  // a read is under way while both strobes are low
  wire rd = !mem_ce_n && !mem_oe_n;
  // cycles the store pin has been driven so far
  reg [15:0] pin_cnt;
  always @(posedge clk_sys) begin
    if (!rst_n || hw_nv_flag_n_oe) begin
      pin_cnt <= 16'h0000;
    end else begin
      pin_cnt <= pin_cnt + 16'h0001;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_we_high: assert property (mem_we_n) else $error("write strobe low");
  a_top_bit: assert property (!mem_addr[AW-1]) else $error("top address bit set");
  a_read_len: assert property ($rose(rd) |-> rd [*2] ##1 !rd) else $error("read length");
  a_addr_held: assert property (rd |-> $stable(mem_addr)) else $error("address moved");
  a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready) else $error("no take");
  a_done_pulse: assert property (cmd_done |=> !cmd_done) else $error("done too long");
  a_pin_low: assert property (!hw_nv_flag_n_oe |-> !hw_nv_flag_n_out) else $error("pin high");
  a_pin_hold: assert property ($rose(hw_nv_flag_n_oe) |-> pin_cnt == STORE_WAIT)
    else $error("pin hold length");
  a_idle_quiet: assert property (cmd_ready |-> mem_ce_n && mem_oe_n && hw_nv_flag_n_oe)
    else $error("port busy while idle");
  c_off: cover property (cmd_done && !want_enabled);
  c_on: cover property (cmd_done && want_enabled);
  c_pin: cover property (!hw_nv_flag_n_oe);
endmodule
bind psc_mode_seq psc_mode_seq_chk #(.AW(AW), .STORE_WAIT(STORE_WAIT)) u_chk (.clk_sys, .rst_n,
  .cmd_valid, .cmd_ready, .cmd_done, .want_enabled, .mem_addr, .mem_ce_n, .mem_oe_n,
  .mem_we_n, .hw_nv_flag_n_out, .hw_nv_flag_n_oe);

// ===== test/psc_dev_model.sv
// behavioural model of the memory's mode-command detector
// assumes: pins from psc_mode_seq, store pin resolved by the bench
`timescale 1ns/1ps
module psc_dev_model (
  input wire [14:0] mem_addr,
  input wire mem_ce_n,
  input wire mem_oe_n,
  input wire mem_we_n,
  input wire hw_nv_flag_n_in,
  input wire pwr_dn,
  input wire ext_wr,
  output reg auto_en,
  output reg nv_en
);
  reg [2:0] step;
  reg written;
  wire rd = !mem_ce_n && !mem_oe_n && mem_we_n;
  // array write by this port or by another master on the bus
  wire wr = (!mem_ce_n && !mem_we_n) || ext_wr;
  wire [13:0] a = mem_addr[13:0];
  // expected prefix address for each step
  function [13:0] pre(input [2:0] s);
    case (s)
      3'h0: pre = 14'h0e38;
      3'h1: pre = 14'h31c7;
      3'h2: pre = 14'h03e0;
      3'h3: pre = 14'h3c1f;
      default: pre = 14'h303f;
    endcase
  endfunction
  // ships with automatic store on and nothing written
  initial begin
    auto_en = 1'b1;
    nv_en = 1'b1;
    step = 3'h0;
    written = 1'b0;
  end
  // prefix tracker, a mismatch starts over
  always @(posedge rd) begin
    if (step == 3'h5 && (a == 14'h03f8 || a == 14'h07f0 || a == 14'h0fc0)) begin
      if (a == 14'h03f8) auto_en = 1'b0;
      if (a == 14'h07f0) auto_en = 1'b1;
      if (a == 14'h0fc0) begin
        nv_en = auto_en;
        written = 1'b0;
      end
      step = 3'h0;
    end else if (step != 3'h5 && a == pre(step)) step = step + 3'h1;
    else step = (a == 14'h0e38) ? 3'h1 : 3'h0;
  end
  // pin store only saves after an array write
  always @(posedge wr) written = 1'b1;
  always @(negedge hw_nv_flag_n_in) begin
    if (written) begin
      nv_en = auto_en;
      written = 1'b0;
    end
  end
  // power cycle recalls the saved setting, never forcing it on
  always @(posedge pwr_dn) begin
    auto_en = nv_en;
    written = 1'b0;
  end
endmodule

// ===== test/psc_mode_seq_tb_top.sv
// self-checking bench for the mode sequencer against the device model
// assumes: rtl sequencer and test model compiled first
`timescale 1ns/1ps
module psc_mode_seq_tb_top;
  reg clk_sys, rst_n, cmd_valid, cmd_enable, cmd_persist, cmd_use_pin, cmd_oe_frame, pwr_dn;
  reg rd_q, ext_wr;
  wire cmd_ready, cmd_done, want_enabled, mem_ce_n, mem_oe_n, mem_we_n, auto_en, nv_en;
  wire hw_nv_flag_n_out, hw_nv_flag_n_oe;
  wire [14:0] mem_addr;
  integer err_count, n_compared, cyc, nreads, pin_lows;
  // pulled up pin, low only while the sequencer drives it
  wire hw_nv_flag_n_in = hw_nv_flag_n_oe ? 1'b1 : hw_nv_flag_n_out;
  psc_mode_seq #(.AW(15), .STORE_WAIT(4)) DUT (.clk_sys, .rst_n, .cmd_valid, .cmd_enable,
    .cmd_persist, .cmd_use_pin, .cmd_oe_frame, .cmd_ready, .cmd_done, .want_enabled, .mem_addr,
    .mem_ce_n, .mem_oe_n, .mem_we_n, .hw_nv_flag_n_in, .hw_nv_flag_n_out, .hw_nv_flag_n_oe);
  psc_dev_model u_dev (.mem_addr, .mem_ce_n, .mem_oe_n, .mem_we_n, .hw_nv_flag_n_in, .pwr_dn,
    .ext_wr, .auto_en, .nv_en);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // read and pin-low counters, cycle ceiling
  always @(posedge clk_sys) begin
    rd_q <= !mem_ce_n && !mem_oe_n;
    if (!mem_ce_n && !mem_oe_n && !rd_q) nreads <= nreads + 1;
    if (!hw_nv_flag_n_in) pin_lows <= pin_lows + 1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      give_verdict;
    end
  end
  task tick;
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task chk(input [8*6-1:0] nm, input [15:0] e, input [15:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("Error %0s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  // one command, then its outcome at the port and in the device
  task run(input en, input pe, input pin, input oe, input [15:0] nr, input dev);
    integer i, n0;
    begin
      n0 = nreads;
      {cmd_enable, cmd_persist, cmd_use_pin, cmd_oe_frame, cmd_valid} = {en, pe, pin, oe, 1'b1};
      tick;
      cmd_valid = 1'b0;
      i = 0;
      while (cmd_done !== 1'b1 && i < 3000) begin
        tick;
        i = i + 1;
      end
      chk("done", 1, cmd_done);
      chk("want", en, want_enabled);
      chk("dev", dev, auto_en);
      chk("reads", nr, nreads - n0);
    end
  endtask
  task do_reset;
    begin
      rst_n = 1'b0;
      repeat (12) tick;
      rst_n = 1'b1;
    end
  endtask
  task pwr_cycle;
    begin
      pwr_dn = 1'b1;
      tick;
      pwr_dn = 1'b0;
    end
  endtask
  task s_reset_state;
    begin
      chk("want", 1, want_enabled);
      chk("dev", 1, auto_en);
    end
  endtask
  // command cut by a reset after five reads, then a clean one
  task s_abort;
    integer n0;
    begin
      n0 = nreads;
      {cmd_enable, cmd_persist, cmd_use_pin, cmd_oe_frame, cmd_valid} = 5'h01;
      tick;
      cmd_valid = 1'b0;
      while (nreads - n0 < 5) tick;
      do_reset;
      chk("want", 1, want_enabled);
      chk("dev", 1, auto_en);
      run(0, 0, 0, 0, 6, 0);
    end
  endtask
  task s_toggle_frames;
    begin
      run(0, 0, 0, 0, 6, 0);
      run(1, 0, 0, 1, 6, 1);
      run(0, 0, 0, 1, 6, 0);
    end
  endtask
  task s_store_sw;
    begin
      run(0, 1, 0, 0, 12, 0);
      pwr_cycle;
      chk("dev", 0, auto_en);
    end
  endtask
  task s_store_pin;
    integer p0;
    begin
      p0 = pin_lows;
      run(1, 1, 1, 1, 6, 1);
      chk("pinlow", 4, pin_lows - p0);
      pwr_cycle;
      chk("dev", 0, auto_en);
      ext_wr = 1'b1;
      tick;
      ext_wr = 1'b0;
      run(1, 1, 1, 0, 6, 1);
      pwr_cycle;
      chk("dev", 1, auto_en);
    end
  endtask
  task s_reissue;
    begin
      do_reset;
      chk("want", 1, want_enabled);
      run(1, 1, 0, 1, 12, 1);
      pwr_cycle;
      chk("dev", 1, auto_en);
    end
  endtask
  task give_verdict;
    begin
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    {rst_n, cmd_valid, cmd_enable, cmd_persist, cmd_use_pin, cmd_oe_frame, pwr_dn, ext_wr} = 8'h00;
    {err_count, n_compared, cyc, nreads, pin_lows} = 160'h0;
    rd_q = 1'b0;
    do_reset;
    s_reset_state;
    s_abort;
    s_toggle_frames;
    s_store_sw;
    s_store_pin;
    s_reissue;
    give_verdict;
  end
endmodule
